// File: sec_pkg.sv
// constants, pin bundle and state type of the serial eeprom host controller
package sec_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // shortest sck high or low phase of the slow supply grade
   localparam int SCK_HALF_NS   = 75;
   localparam int SCK_HALF_CYC  =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_PWRUP_MS    = 1;
   localparam int PWRUP_CYC     = T_PWRUP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int T_WC_MS       = 5;
   localparam int WC_CYC        = T_WC_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TIMER_W       = 20;
   localparam int FRAME_W       = 32;

   // ------------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_SET_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] CMD_CLEAR_WRITE_ENABLE = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS        = 8'h05;
   localparam logic [7:0] CMD_WRITE_STATUS       = 8'h01;
   localparam logic [7:0] CMD_READ_MEMORY        = 8'h03;
   localparam logic [7:0] CMD_WRITE_MEMORY       = 8'h02;

   // ------------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_CTRL   = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA  = 8'h14;

   localparam int CTRL_WP_N_BIT  = 0;
   localparam int CTRL_PAUSE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_PWR_BIT     = 1;
   localparam int STAT_WAIT_BIT    = 2;
   localparam int STAT_REFUSED_BIT = 3;
   localparam int STAT_WEN_BIT     = 4;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
      logic wp_n;
   } sec_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_PAUSE, ST_CSHOLD, ST_GAP
   } sec_state_t;

endpackage

// File: sec_host.sv
// host controller that drives a serial eeprom over its spi pins
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - host frames each transaction with cs edges
// - host toggles pause only with sck low
// - read: opcode, address, then clock data out
// - host sets write enable before writing
// - host waits 5 ms after write frame
// - host waits 1 ms after power up
module sec_host #(
   parameter int unsigned PWRUP_CYCLES = sec_pkg::PWRUP_CYC,
   parameter int unsigned WC_CYCLES    = sec_pkg::WC_CYC,
   parameter int unsigned SCK_HALF     = sec_pkg::SCK_HALF_CYC
) (
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // device pins
   output sec_pkg::sec_pins_t     pins,
   input  wire logic              so
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic is_known(input logic [7:0] op);
      is_known = (op == sec_pkg::CMD_SET_WRITE_ENABLE)   ||
                 (op == sec_pkg::CMD_CLEAR_WRITE_ENABLE) ||
                 (op == sec_pkg::CMD_READ_STATUS)        ||
                 (op == sec_pkg::CMD_WRITE_STATUS)       ||
                 (op == sec_pkg::CMD_READ_MEMORY)        ||
                 (op == sec_pkg::CMD_WRITE_MEMORY);
   endfunction

   function automatic logic is_write(input logic [7:0] op);
      is_write = (op == sec_pkg::CMD_WRITE_STATUS) ||
                 (op == sec_pkg::CMD_WRITE_MEMORY);
   endfunction

   localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

   sec_pkg::sec_state_t             state_reg;
   logic [7:0]                      div_reg;
   logic [sec_pkg::FRAME_W-1:0]     tx_reg;
   logic [7:0]                      rx_reg;
   logic [5:0]                      bitcnt_reg;
   logic                            cs_n_reg;
   logic                            sck_reg;
   logic                            hold_n_reg;
   logic [7:0]                      cur_op_reg;
   logic [7:0]                      op_reg;
   logic [15:0]                     addr_reg;
   logic [7:0]                      wdata_reg;
   logic [1:0]                      ctrl_reg;
   logic                            refused_reg;
   logic                            write_enable_latch_bit_reg;
   logic [sec_pkg::TIMER_W-1:0]     pwr_cnt_reg;
   logic [sec_pkg::TIMER_W-1:0]     wc_cnt_reg;
   logic [2:0]                      so_ff;
   logic                            so_s;
   logic                            div_zero;
   logic                            pwr_done;
   logic                            write_wait;
   logic                            cmd_wr;
   logic                            accept;
   logic                            cs_rise;
   logic                            pause_req;
   logic [7:0]                      new_op;

   assign div_zero   = (div_reg == 8'h00);
   assign pwr_done   = (pwr_cnt_reg == '0);
   assign write_wait = (wc_cnt_reg != '0);
   assign pause_req  = ctrl_reg[sec_pkg::CTRL_PAUSE_BIT];
   assign new_op     = reg_wdata[7:0];
   assign cmd_wr     = reg_wr && (reg_addr == sec_pkg::REG_CMD);
   assign cs_rise    = (state_reg == sec_pkg::ST_CSHOLD) && div_zero;

   // refuse anything the device would drop as unknown, early, busy or write disabled, or that breaks host duties
   assign accept = cmd_wr && (state_reg == sec_pkg::ST_IDLE) &&
      pwr_done &&
      is_known(new_op) &&
      (!write_wait || new_op == sec_pkg::CMD_READ_STATUS) &&
      (!is_write(new_op) || write_enable_latch_bit_reg);

   // ------------------------------------------------------------------
   // serial output synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         so_ff <= 3'h0;
         so_s  <= 1'b0;
      end else if (ce) begin
         so_ff <= {so_ff[1:0], so};
         if (so_ff[1] == so_ff[2]) begin
            so_s <= so_ff[2];
         end
      end
   end

   // ------------------------------------------------------------------
   // half-period divider
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg <= 8'h00;
      end else if (ce) begin
         if (state_reg == sec_pkg::ST_IDLE || div_zero) begin
            div_reg <= HALF_M1;
         end else begin
            div_reg <= div_reg - 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // frame engine, mode 0: sck idles low
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg  <= sec_pkg::ST_IDLE;
         tx_reg     <= '0;
         rx_reg     <= 8'h00;
         bitcnt_reg <= 6'h00;
         cs_n_reg   <= 1'b1;
         sck_reg    <= 1'b0;
         hold_n_reg <= 1'b1;
         cur_op_reg <= 8'h00;
      end else if (ce) begin
         unique case (state_reg)
            sec_pkg::ST_IDLE: begin
               if (accept) begin
                  cur_op_reg <= new_op;
                  cs_n_reg   <= 1'b0;
                  state_reg  <= sec_pkg::ST_SETUP;
                  // opcode first, then address or data on one line
                  if (new_op == sec_pkg::CMD_READ_MEMORY ||
                      new_op == sec_pkg::CMD_WRITE_MEMORY) begin
                     tx_reg     <= {new_op, addr_reg, wdata_reg};
                     bitcnt_reg <= 6'h20;
                  end else if (new_op == sec_pkg::CMD_READ_STATUS ||
                               new_op == sec_pkg::CMD_WRITE_STATUS) begin
                     tx_reg     <= {new_op, wdata_reg, 16'h0000};
                     bitcnt_reg <= 6'h10;
                  end else begin
                     tx_reg     <= {new_op, 24'h000000};
                     bitcnt_reg <= 6'h08;
                  end
               end
            end
            sec_pkg::ST_SETUP: begin
               if (div_zero) begin
                  sck_reg    <= 1'b1;
                  rx_reg     <= {rx_reg[6:0], so_s};
                  bitcnt_reg <= bitcnt_reg - 6'h01;
                  state_reg  <= sec_pkg::ST_HIGH;
               end
            end
            sec_pkg::ST_HIGH: begin
               if (div_zero) begin
                  sck_reg <= 1'b0;
                  if (bitcnt_reg == 6'h00) begin
                     state_reg <= sec_pkg::ST_CSHOLD;
                  end else begin
                     // new si bit well before the next rising edge
                     tx_reg    <= {tx_reg[sec_pkg::FRAME_W-2:0], 1'b0};
                     state_reg <= sec_pkg::ST_LOW;
                  end
               end
            end
            sec_pkg::ST_LOW: begin
               if (div_zero) begin
                  if (pause_req) begin
                     hold_n_reg <= 1'b0;
                     state_reg  <= sec_pkg::ST_PAUSE;
                  end else begin
                     sck_reg    <= 1'b1;
                     rx_reg     <= {rx_reg[6:0], so_s};
                     bitcnt_reg <= bitcnt_reg - 6'h01;
                     state_reg  <= sec_pkg::ST_HIGH;
                  end
               end
            end
            sec_pkg::ST_PAUSE: begin
               // frame position is kept, so nothing is resent
               if (div_zero && !pause_req) begin
                  hold_n_reg <= 1'b1;
                  state_reg  <= sec_pkg::ST_LOW;
               end
            end
            sec_pkg::ST_CSHOLD: begin
               if (div_zero) begin
                  cs_n_reg  <= 1'b1;
                  state_reg <= sec_pkg::ST_GAP;
               end
            end
            sec_pkg::ST_GAP: begin
               if (div_zero) begin
                  state_reg <= sec_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // power-up and write-cycle timers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pwr_cnt_reg <= sec_pkg::TIMER_W'(PWRUP_CYCLES);
         wc_cnt_reg  <= '0;
      end else if (ce) begin
         if (!pwr_done) begin
            pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
         end
         if (cs_rise && is_write(cur_op_reg)) begin
            wc_cnt_reg <= sec_pkg::TIMER_W'(WC_CYCLES);
         end else if (write_wait) begin
            wc_cnt_reg <= wc_cnt_reg - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // host copy of the device write enable latch
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         write_enable_latch_bit_reg <= 1'b0;
      end else if (ce && cs_rise) begin
         if (cur_op_reg == sec_pkg::CMD_SET_WRITE_ENABLE) begin
            write_enable_latch_bit_reg <= 1'b1;
         end else if (cur_op_reg == sec_pkg::CMD_CLEAR_WRITE_ENABLE ||
                      is_write(cur_op_reg)) begin
            // cs rise after a write frame clears the copy, as the device clears its latch for each write it accepts
            write_enable_latch_bit_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         op_reg    <= 8'h00;
         addr_reg  <= 16'h0000;
         wdata_reg <= 8'h00;
         ctrl_reg  <= sec_pkg::CTRL_RESET;
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            sec_pkg::REG_CMD:   op_reg    <= new_op;
            sec_pkg::REG_ADDR:  addr_reg  <= reg_wdata[15:0];
            sec_pkg::REG_WDATA: wdata_reg <= reg_wdata[7:0];
            sec_pkg::REG_CTRL:  ctrl_reg  <= reg_wdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // refusal flag: a new refusal beats a clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refused_reg <= 1'b0;
      end else if (ce) begin
         if (cmd_wr && !accept) begin
            refused_reg <= 1'b1;
         end else if (reg_wr && reg_addr == sec_pkg::REG_STATUS &&
                      reg_wdata[sec_pkg::STAT_REFUSED_BIT]) begin
            refused_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            unique case (reg_addr)
               sec_pkg::REG_CMD:   reg_rdata <= {24'h000000, op_reg};
               sec_pkg::REG_ADDR:  reg_rdata <= {16'h0000, addr_reg};
               sec_pkg::REG_WDATA: reg_rdata <= {24'h000000, wdata_reg};
               sec_pkg::REG_CTRL:  reg_rdata <= {30'h00000000, ctrl_reg};
               sec_pkg::REG_STATUS: begin
                  reg_rdata <= {27'h0000000, write_enable_latch_bit_reg,
                     refused_reg, write_wait, pwr_done,
                     state_reg != sec_pkg::ST_IDLE};
               end
               sec_pkg::REG_RDATA: reg_rdata <= {24'h000000, rx_reg};
               default:            reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_comb begin
      pins.cs_n   = cs_n_reg;
      pins.sck    = sck_reg;
      pins.si     = tx_reg[sec_pkg::FRAME_W-1];
      pins.hold_n = hold_n_reg;
      pins.wp_n   = ctrl_reg[sec_pkg::CTRL_WP_N_BIT];
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   property p_cs_edges;
      @(posedge clk) disable iff (reset)
      ($fell(pins.cs_n) || $rose(pins.cs_n)) |-> !pins.sck;
   endproperty
   a_cs_edges: assert property (p_cs_edges)
      else $error("chip select moved while sck high");

   property p_hold_change;
      @(posedge clk) disable iff (reset)
      $changed(pins.hold_n) |-> !pins.sck && !pins.cs_n;
   endproperty
   a_hold_change: assert property (p_hold_change)
      else $error("pause pin moved while sck high");

   property p_pause_still;
      @(posedge clk) disable iff (reset)
      (!pins.hold_n && !$past(pins.hold_n)) |->
         $stable(pins.sck) && $stable(pins.si) && !pins.cs_n;
   endproperty
   a_pause_still: assert property (p_pause_still)
      else $error("bus moved during pause");

   property p_pwrup;
      @(posedge clk) disable iff (reset)
      !pwr_done |-> pins.cs_n;
   endproperty
   a_pwrup: assert property (p_pwrup)
      else $error("frame started before power-up wait");

   property p_busy_only_status;
      @(posedge clk) disable iff (reset)
      ($fell(pins.cs_n) && write_wait) |->
         cur_op_reg == sec_pkg::CMD_READ_STATUS;
   endproperty
   a_busy_only_status: assert property (p_busy_only_status)
      else $error("non status command during write cycle");

   property p_wc_load;
      @(posedge clk) disable iff (reset)
      (ce && cs_rise && is_write(cur_op_reg)) |=>
         wc_cnt_reg == sec_pkg::TIMER_W'(WC_CYCLES) && pins.cs_n;
   endproperty
   a_wc_load: assert property (p_wc_load)
      else $error("write cycle wait not started at cs rise");

   property p_enable_first;
      @(posedge clk) disable iff (reset)
      ($fell(pins.cs_n) && is_write(cur_op_reg)) |->
         write_enable_latch_bit_reg;
   endproperty
   a_enable_first: assert property (p_enable_first)
      else $error("write sent without write enable");

   property p_read_frame;
      @(posedge clk) disable iff (reset)
      ($fell(pins.cs_n) && cur_op_reg == sec_pkg::CMD_READ_MEMORY) |->
         bitcnt_reg == 6'h20 && tx_reg[31:24] == cur_op_reg;
   endproperty
   a_read_frame: assert property (p_read_frame)
      else $error("memory read frame has wrong length");

   property p_sck_high;
      @(posedge clk) disable iff (reset)
      $rose(pins.sck) |-> pins.sck[*8];
   endproperty
   a_sck_high: assert property (p_sck_high)
      else $error("sck high phase too short");

   property p_rdata;
      @(posedge clk) disable iff (reset)
      (ce && reg_rd && reg_addr == sec_pkg::REG_RDATA) |=>
         reg_rdata == {24'h000000, $past(rx_reg)};
   endproperty
   a_rdata: assert property (p_rdata)
      else $error("received byte not returned");

endmodule

// File: sec_dev_model.sv
// behavioural serial eeprom answering the host controller
`timescale 1ns/1ps
module sec_dev_model #(
   parameter realtime PU_NS = 150.0,
   parameter realtime WC_NS = 400.0
) (
   // pins from the host
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic hold_n,
   input  wire logic wp_n,
   // data back to the host
   output logic      so
);
   logic [7:0]  mem [0:4095];
   logic [7:0]  sh, op, wsr, sv;
   logic [15:0] adr;
   logic        protect_pin_enable_bit, write_enable_latch_bit, obit, drive;
   logic [1:0]  bp;
   realtime     busy_to;
   int          cnt;
   initial begin
      protect_pin_enable_bit = 1'b0;
      bp = 2'h0;
      write_enable_latch_bit = 1'b0;
      obit = 1'b0;
      drive = 1'b0;
      busy_to = 0.0;
      cnt = 0;
      op = 8'h00;
   end
   // no pull on this line: a released output shows the inverse bit
   assign so = (drive && !cs_n && hold_n) ? obit : ~obit;
   always @(negedge cs_n) begin
      cnt = 0;
   end
   always @(posedge sck) begin
      if (!cs_n && hold_n && $realtime >= PU_NS) begin
         sh = {sh[6:0], si};
         cnt = cnt + 1;
         if (cnt == 8) begin
            op = ($realtime < busy_to && sh != 8'h05) ? 8'hff : sh;
         end
         if (cnt > 8 && cnt <= 24) begin
            adr = {adr[14:0], si};
         end
         if (cnt == 16) begin
            wsr = sh;
         end
      end
   end
   always @(negedge sck) begin
      if (!cs_n && hold_n && cnt >= 8) begin
         sv = {protect_pin_enable_bit, 3'h0, bp, write_enable_latch_bit, $realtime < busy_to};
         if (op == 8'h05 && cnt < 16) begin
            obit = sv[15-cnt];
            drive = 1'b1;
         end
         if (op == 8'h03 && cnt >= 24 && cnt < 32) begin
            obit = mem[adr[11:0]][31-cnt];
            drive = 1'b1;
         end
      end
   end
   // a short frame leaves op unmatched, so partial opcodes are dropped
   always @(posedge cs_n) begin
      drive = 1'b0;
      if (cnt == 8 && op == 8'h06) write_enable_latch_bit = 1'b1;
      if (cnt == 8 && op == 8'h04) write_enable_latch_bit = 1'b0;
      // status write needs the latch and no active pin lock
      if (cnt == 16 && op == 8'h01 && write_enable_latch_bit
          && (wp_n || !protect_pin_enable_bit)) begin
         protect_pin_enable_bit = wsr[7];
         bp = wsr[3:2];
         busy_to = $realtime + WC_NS;
         write_enable_latch_bit = 1'b0;
      end
      if (cnt == 32 && op == 8'h02 && write_enable_latch_bit && !(bp == 2'h3
          || (bp == 2'h2 && adr[11]) || (bp == 2'h1 && &adr[11:10])))
      begin
         mem[adr[11:0]] = sh;
         busy_to = $realtime + WC_NS;
         write_enable_latch_bit = 1'b0;
      end
      op = 8'h00;
   end
endmodule

// File: tb_sec_host.sv
// self-checking bench of the serial eeprom host controller
`timescale 1ns/1ps
module tb_sec_host;
   logic               clk, reset, ce, reg_wr, reg_rd, so, hold_q;
   logic [7:0]         reg_addr, d;
   logic [31:0]        reg_wdata, reg_rdata, rv;
   logic [15:0]        a;
   sec_pkg::sec_pins_t pins, pins_q;
   logic [7:0]         exp_mem [int];
   int                 num_errors, num_checks, seed;

   sec_host #(.PWRUP_CYCLES(20), .WC_CYCLES(50), .SCK_HALF(8)) DUT (
      .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pins(pins), .so(so));
   sec_dev_model MODEL (.cs_n(pins.cs_n), .sck(pins.sck), .si(pins.si),
      .hold_n(pins.hold_n), .wp_n(pins.wp_n), .so(so));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         num_errors++;
      end
   endtask
   task wr(logic [7:0] ad, logic [31:0] dt);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(logic [7:0] ad);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task wait_idle(logic [31:0] mask);
      int i;
      for (i = 0; i < 1000; i++) begin
         rd(sec_pkg::REG_STATUS);
         if ((rv & mask) == 32'h0) break;
      end
      check("idle in time", i < 1000, 1);
   endtask
   task run(logic [7:0] op);
      wr(sec_pkg::REG_CMD, {24'h0, op});
      wait_idle(32'h1);
   endtask
   task stat_chk(logic [7:0] exp);
      run(sec_pkg::CMD_READ_STATUS);
      rd(sec_pkg::REG_RDATA);
      check("status byte", rv, {24'h0, exp});
   endtask
   task refused_chk();
      rd(sec_pkg::REG_STATUS);
      check("refused flag", rv[3], 1);
      wr(sec_pkg::REG_STATUS, 32'h8);
   endtask
   task end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // pause may only toggle while the serial clock rests low
   always @(posedge clk) begin
      hold_q <= pins.hold_n;
      if (!reset && hold_q !== pins.hold_n)
         check("sck at pause", pins.sck, 0);
   end

   initial begin
      #400us;
      $display("watchdog expired");
      num_errors++;
      end_of_test();
   end

   initial begin
      seed = 80;
      num_errors = 0;
      num_checks = 0;
      ce = 1'b1;
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rd(sec_pkg::REG_CTRL);
      check("ctrl reset", rv, 32'h1);
      wr(sec_pkg::REG_CMD, 32'h06);
      rd(sec_pkg::REG_STATUS);
      check("early command", rv[3:1], 3'h4);
      repeat (25) @(posedge clk);
      wr(sec_pkg::REG_STATUS, 32'h8);
      rd(sec_pkg::REG_STATUS);
      check("power up done", rv[3:1], 3'h1);
      $display("test power_up done");
      a = $random(seed);
      d = $random(seed);
      run(sec_pkg::CMD_SET_WRITE_ENABLE);
      stat_chk(8'h02);
      wr(sec_pkg::REG_ADDR, {16'h0, a});
      wr(sec_pkg::REG_WDATA, {24'h0, d});
      run(sec_pkg::CMD_WRITE_MEMORY);
      exp_mem[a[11:0]] = d;
      wr(sec_pkg::REG_CMD, 32'h06);
      refused_chk();
      wait_idle(32'h5);
      wr(sec_pkg::REG_ADDR, {16'h0, ~a[15:12], a[11:0]});
      run(sec_pkg::CMD_READ_MEMORY);
      rd(sec_pkg::REG_RDATA);
      check("read byte", rv, {24'h0, exp_mem[a[11:0]]});
      $display("test memory done");
      wr(sec_pkg::REG_CMD, 32'h03);
      repeat (150) @(posedge clk);
      wr(sec_pkg::REG_CTRL, 32'h3);
      repeat (80) @(posedge clk);
      wr(sec_pkg::REG_CTRL, 32'h1);
      wait_idle(32'h1);
      rd(sec_pkg::REG_RDATA);
      check("paused read", rv, {24'h0, exp_mem[a[11:0]]});
      $display("test pause done");
      run(sec_pkg::CMD_SET_WRITE_ENABLE);
      wr(sec_pkg::REG_WDATA, 32'h80);
      run(sec_pkg::CMD_WRITE_STATUS);
      wait_idle(32'h5);
      stat_chk(8'h80);
      wr(sec_pkg::REG_CTRL, 32'h0);
      run(sec_pkg::CMD_SET_WRITE_ENABLE);
      wr(sec_pkg::REG_WDATA, 32'h8c);
      run(sec_pkg::CMD_WRITE_STATUS);
      wait_idle(32'h5);
      stat_chk(8'h82);
      run(sec_pkg::CMD_CLEAR_WRITE_ENABLE);
      stat_chk(8'h80);
      wr(sec_pkg::REG_CMD, 32'h02);
      refused_chk();
      wr(sec_pkg::REG_CMD, 32'hff);
      refused_chk();
      rd(8'h3c);
      check("unmapped read", rv, 32'h0);
      wr(sec_pkg::REG_CTRL, 32'h1);
      run(sec_pkg::CMD_SET_WRITE_ENABLE);
      run(sec_pkg::CMD_WRITE_STATUS);
      wait_idle(32'h5);
      stat_chk(8'h8c);
      $display("test protect done");
      // clock enable low must freeze the frame midway, then let it finish
      wr(sec_pkg::REG_CMD, {24'h0, sec_pkg::CMD_SET_WRITE_ENABLE});
      repeat (40) @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      pins_q = pins;
      repeat (30) @(posedge clk);
      check("frozen pins", pins, pins_q);
      ce <= 1'b1;
      wait_idle(32'h1);
      stat_chk(8'h8e);
      $display("test clock enable done");
      end_of_test();
   end
endmodule
